// ==== src/touch_regs_pkg.sv ====
// constants, field layouts and types for the touch register bank
package touch_regs_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned ADDR_LSB      = 2;
   localparam int unsigned IDX_W         = 8;
   localparam logic [7:0] IDX_BUF  = 8'h02;
   localparam logic [7:0] IDX_REF  = 8'h03;
   localparam logic [7:0] IDX_RST  = 8'h04;
   localparam logic [7:0] IDX_CFG  = 8'h05;
   localparam logic [7:0] IDX_DATA = 8'h10;
   localparam logic [15:0] RESET_CMD   = 16'hbb00;
   localparam logic [15:0] RST_REG_DEF = 16'hffff;
   localparam int unsigned BUF_CTL_LSB = 11;
   localparam int unsigned BUF_FULL_BIT  = 10;
   localparam int unsigned BUF_EMPTY_BIT = 9;
   localparam int unsigned TL_STEP = 8;
   localparam int unsigned TMR_W   = 17;
   typedef struct packed {
      logic       en;
      logic       single;
      logic [2:0] tl;
   } buf_ctl_t;
   typedef struct packed {
      logic       rsv;
      logic       internal;
      logic [1:0] dly;
      logic       pdn;
      logic       level;
   } ref_ctl_t;
   typedef struct packed {
      logic       pdn;
      logic [2:0] pre;
      logic [2:0] sense;
   } pen_cfg_t;
   localparam buf_ctl_t BUF_CTL_DEF = 5'h00;
   localparam ref_ctl_t REF_CTL_DEF = 6'h02;
   localparam pen_cfg_t PEN_CFG_DEF = 7'h00;
   typedef enum logic [1:0] {
      PEN_IDLE      = 2'b00,
      PEN_PRECHARGE = 2'b01,
      PEN_SENSE     = 2'b10
   } pen_state_t;
   typedef int unsigned tab4_t [4];
   typedef int unsigned tab8_t [8];
   localparam tab4_t REF_DLY_NS = '{0, 100000, 500000, 1000000};
   localparam tab8_t PRE_NS = '{20000, 84000, 276000, 340000,
                                1044000, 1300000, 1300000, 1364000};
   localparam tab8_t SENSE_NS = '{32000, 96000, 544000, 608000,
                                  2080000, 2144000, 2592000, 2656000};
   // least times: round up, zero stays zero
   function automatic int unsigned ns2cyc(input int unsigned ns);
      return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   endfunction : ns2cyc
   localparam tab4_t REF_DLY_CYC = '{ns2cyc(REF_DLY_NS[0]), ns2cyc(REF_DLY_NS[1]),
                                     ns2cyc(REF_DLY_NS[2]), ns2cyc(REF_DLY_NS[3])};
   localparam tab8_t PRE_CYC = '{ns2cyc(PRE_NS[0]), ns2cyc(PRE_NS[1]), ns2cyc(PRE_NS[2]),
                                 ns2cyc(PRE_NS[3]), ns2cyc(PRE_NS[4]), ns2cyc(PRE_NS[5]),
                                 ns2cyc(PRE_NS[6]), ns2cyc(PRE_NS[7])};
   localparam tab8_t SENSE_CYC = '{ns2cyc(SENSE_NS[0]), ns2cyc(SENSE_NS[1]),
                                   ns2cyc(SENSE_NS[2]), ns2cyc(SENSE_NS[3]),
                                   ns2cyc(SENSE_NS[4]), ns2cyc(SENSE_NS[5]),
                                   ns2cyc(SENSE_NS[6]), ns2cyc(SENSE_NS[7])};
endpackage : touch_regs_pkg

// ==== src/touch_regs.sv ====
// touch converter buffer, reference and pen-detect register bank
//
// Functional notes
// [RL1] enable bit low clears and holds pointers
// [RL2] mode bit: continuous or single shot
// [RL3] trigger level is eight times code plus one
// [RL4] full flag set at 64 unread results
// [RL5] empty flag set when nothing unread
// [RL6] reference source: external or internal
// [RL7] reference settle delay 0/100/500/1000 us
// [RL8] delay only when internal and powered down
// [RL9] power-down bit: always on or between conversions
// [RL10] external mode keeps internal reference off
// [RL11] level bit selects 1.25 V or 2.50 V
// [RL12] software writes zero to reserved bit
// [RL13] reset command restores all control defaults
// [RL14] software writes only the reset command
// [RL15] pen detect enabled when bit low
// [RL16] precharge panel for programmed time
// [RL17] sense for programmed time before sampling
// [RL18] channel status invalid in buffer mode
// [RL19] circular 64-entry store, flags from pointers
// [RL20] counters time delays, reserved reads zero; the REF rsv bit reads back as written
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module touch_regs #(
   parameter int unsigned DW    = 12,
   parameter int unsigned DEPTH = 64,
   parameter int unsigned AW    = 12,
   parameter touch_regs_pkg::tab4_t REF_DLY_CYC = touch_regs_pkg::REF_DLY_CYC,
   parameter touch_regs_pkg::tab8_t PRE_CYC     = touch_regs_pkg::PRE_CYC,
   parameter touch_regs_pkg::tab8_t SENSE_CYC   = touch_regs_pkg::SENSE_CYC
) (
   input  wire logic          sys_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [AW-1:0] paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output logic               pready_o,
   output logic [31:0]        prdata_o,
   output logic               pslverr_o,
   input  wire logic          sample_valid_i,
   input  wire logic [DW-1:0] sample_data_i,
   input  wire logic          conv_active_i,
   input  wire logic          pen_pin_i,
   output logic               conv_allow_o,
   output logic               buffer_trigger_o,
   output logic               chan_status_valid_o,
   output logic               ref_internal_o,
   output logic               ref_power_on_o,
   output logic               ref_level_o,
   output logic               ref_settled_o,
   output logic               pen_detect_enable_o,
   output logic               panel_precharge_o,
   output logic               panel_sense_o,
   output logic               pen_touch_o
);
   import touch_regs_pkg::*;

   localparam int unsigned PW = $clog2(DEPTH) + 1;

   // register state
   buf_ctl_t    buf_ctl_q, buf_ctl_d;
   ref_ctl_t    ref_ctl_q, ref_ctl_d;
   pen_cfg_t    pen_cfg_q, pen_cfg_d;
   logic [15:0] rst_reg_q, rst_reg_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;

   // decode
   logic [IDX_W-1:0] idx;
   logic             hit_buf, hit_ref, hit_rst, hit_cfg, hit_data, mapped;
   logic             setup, done, wr_done, rd_done, soft_rst;

   // buffer state
   logic [DW-1:0]   mem [DEPTH];
   logic [PW-1:0]   wr_ptr_q, wr_ptr_d;
   logic [PW-1:0]   rd_ptr_q, rd_ptr_d;
   logic [PW-1:0]   tg_ptr_q, tg_ptr_d;
   logic [PW-1:0]   count, level;
   logic            full, empty, push, pop;
   logic            allow_q, allow_d, trig_q, trig_d, stat_q, stat_d;

   // reference state
   logic [TMR_W-1:0] rcnt_q, rcnt_d;
   logic             rpow_q, rpow_d, rset_q, rset_d;
   logic             rint_q, rint_d, rlvl_q, rlvl_d;

   // pen detect state
   pen_state_t       pst_q, pst_d;
   logic [TMR_W-1:0] pcnt_q, pcnt_d;
   logic [1:0]       pen_sync_q;
   logic             touch_q, touch_d, pen_en_q, pen_en_d;
   logic             prech_q, prech_d, sense_q, sense_d;

   assign idx      = paddr_i[ADDR_LSB +: IDX_W];
   assign hit_buf  = (idx == IDX_BUF);
   assign hit_ref  = (idx == IDX_REF);
   assign hit_rst  = (idx == IDX_RST);
   assign hit_cfg  = (idx == IDX_CFG);
   assign hit_data = (idx == IDX_DATA);
   assign mapped   = hit_buf | hit_ref | hit_rst | hit_cfg | hit_data;
   assign setup    = psel_i & ~penable_i;
   assign done     = psel_i & penable_i & pready_q;
   assign wr_done  = done & pwrite_i & mapped;
   assign rd_done  = done & ~pwrite_i;
   // RL13 reset command decode
   assign soft_rst = wr_done & hit_rst & (pwdata_i[15:0] == RESET_CMD);

   // RL19 pointer difference gives fill
   assign count = wr_ptr_q - rd_ptr_q;
   // RL4 full at DEPTH unread
   assign full  = (count == PW'(DEPTH));
   // RL5 empty when pointers meet
   assign empty = (count == '0);
   // RL3 level is (code + 1) * 8
   assign level = PW'((int'(buf_ctl_q.tl) + 1) * TL_STEP);
   // RL2 single shot stops at the trigger level
   assign allow_d = buf_ctl_q.en & ~full & (~buf_ctl_q.single | (count < level));
   // allow_q lags the fill by a cycle, so single shot rechecks here
   assign push    = sample_valid_i & allow_q & ~full & (~buf_ctl_q.single | (count < level));
   assign pop     = rd_done & hit_data & ~empty & buf_ctl_q.en;

   // apb answer: no wait state, data picked in setup
   always_comb begin
      pready_d  = setup & ~pready_q;
      pslverr_d = pslverr_q;
      prdata_d  = prdata_q;
      if (setup) begin
         pslverr_d = ~mapped;
         prdata_d  = '0;
         // RL20 reserved bits read zero, except the REF rsv bit, which reads back as written
         if (hit_buf) begin
            prdata_d[BUF_CTL_LSB +: $bits(buf_ctl_t)] = buf_ctl_q;
            prdata_d[BUF_FULL_BIT]  = full;
            prdata_d[BUF_EMPTY_BIT] = empty;
         end else if (hit_ref) begin
            prdata_d[$bits(ref_ctl_t)-1:0] = ref_ctl_q;
         end else if (hit_rst) begin
            prdata_d[15:0] = rst_reg_q;
         end else if (hit_cfg) begin
            prdata_d[$bits(pen_cfg_t)-1:0] = pen_cfg_q;
         end else if (hit_data && !empty) begin
            prdata_d[DW-1:0] = mem[rd_ptr_q[PW-2:0]];
         end
      end
   end

   // control register writes
   always_comb begin
      buf_ctl_d = buf_ctl_q;
      ref_ctl_d = ref_ctl_q;
      pen_cfg_d = pen_cfg_q;
      rst_reg_d = rst_reg_q;
      if (soft_rst) begin
         // RL13 all control fields to defaults
         buf_ctl_d = BUF_CTL_DEF;
         ref_ctl_d = REF_CTL_DEF;
         pen_cfg_d = PEN_CFG_DEF;
         rst_reg_d = RST_REG_DEF;
      end else if (wr_done) begin
         if (hit_buf) begin
            buf_ctl_d = pwdata_i[BUF_CTL_LSB +: $bits(buf_ctl_t)];
         end else if (hit_ref) begin
            // RL12 reserved bit kept as written
            ref_ctl_d = pwdata_i[$bits(ref_ctl_t)-1:0];
         end else if (hit_rst) begin
            // RL14 other codes only stored
            rst_reg_d = pwdata_i[15:0];
         end else if (hit_cfg) begin
            pen_cfg_d = pwdata_i[$bits(pen_cfg_t)-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         buf_ctl_q <= BUF_CTL_DEF;
         ref_ctl_q <= REF_CTL_DEF;
         pen_cfg_q <= PEN_CFG_DEF;
         rst_reg_q <= RST_REG_DEF;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         buf_ctl_q <= buf_ctl_d;
         ref_ctl_q <= ref_ctl_d;
         pen_cfg_q <= pen_cfg_d;
         rst_reg_q <= rst_reg_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // buffer pointers and flags
   always_comb begin
      wr_ptr_d = wr_ptr_q + PW'(push);
      rd_ptr_d = rd_ptr_q + PW'(pop);
      tg_ptr_d = rd_ptr_d + level;
      trig_d   = buf_ctl_q.en & (count >= level);
      // RL18 channel status only outside buffer mode
      stat_d   = ~buf_ctl_q.en;
      // RL1 disabled buffer holds pointers at zero
      if (!buf_ctl_q.en || soft_rst) begin
         wr_ptr_d = '0;
         rd_ptr_d = '0;
         tg_ptr_d = '0;
         trig_d   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         tg_ptr_q <= '0;
         allow_q  <= 1'b0;
         trig_q   <= 1'b0;
         stat_q   <= 1'b1;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         tg_ptr_q <= tg_ptr_d;
         allow_q  <= allow_d;
         trig_q   <= trig_d;
         stat_q   <= stat_d;
      end
   end

   // storage needs no reset; only read below the write pointer
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr_q[PW-2:0]] <= sample_data_i;
      end
   end

   // reference power and settling
   always_comb begin
      // RL6 source select
      rint_d = ref_ctl_q.internal;
      // RL11 level select
      rlvl_d = ref_ctl_q.level;
      // RL9 RL10 power policy
      rpow_d = ref_ctl_q.internal & (~ref_ctl_q.pdn | conv_active_i);
      rcnt_d = '0;
      rset_d = 1'b0;
      if (rpow_q) begin
         // RL8 delay only when powered down between uses
         if (!ref_ctl_q.pdn) begin
            rset_d = 1'b1;
         // RL7 RL20 count the settle delay
         end else if (rcnt_q >= TMR_W'(REF_DLY_CYC[ref_ctl_q.dly])) begin
            rset_d = 1'b1;
            rcnt_d = rcnt_q;
         end else begin
            rcnt_d = rcnt_q + 1'b1;
         end
      end
      if (!rpow_d) begin
         rset_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rcnt_q <= '0;
         rpow_q <= 1'b0;
         rset_q <= 1'b0;
         rint_q <= 1'b0;
         rlvl_q <= 1'b0;
      end else begin
         rcnt_q <= rcnt_d;
         rpow_q <= rpow_d;
         rset_q <= rset_d;
         rint_q <= rint_d;
         rlvl_q <= rlvl_d;
      end
   end

   // pen detect: precharge, then sense, then sample
   always_comb begin
      pst_d    = pst_q;
      pcnt_d   = pcnt_q + 1'b1;
      touch_d  = touch_q;
      // RL15 power-down bit gates detection
      pen_en_d = ~pen_cfg_q.pdn;
      case (pst_q)
         PEN_IDLE: begin
            pcnt_d = '0;
            if (pen_en_q) begin
               pst_d = PEN_PRECHARGE;
            end
         end
         PEN_PRECHARGE: begin
            // RL16 precharge time
            if (pcnt_q >= TMR_W'(PRE_CYC[pen_cfg_q.pre] - 1)) begin
               pst_d  = PEN_SENSE;
               pcnt_d = '0;
            end
         end
         PEN_SENSE: begin
            // RL17 sense time, then sample pin
            if (pcnt_q >= TMR_W'(SENSE_CYC[pen_cfg_q.sense] - 1)) begin
               pst_d   = PEN_PRECHARGE;
               pcnt_d  = '0;
               touch_d = pen_sync_q[1];
            end
         end
         default: begin
            pst_d = PEN_IDLE;
         end
      endcase
      // disabling stops the cycle at once
      if (!pen_en_q) begin
         pst_d   = PEN_IDLE;
         pcnt_d  = '0;
         touch_d = 1'b0;
      end
      prech_d = (pst_d == PEN_PRECHARGE);
      sense_d = (pst_d == PEN_SENSE);
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pst_q      <= PEN_IDLE;
         pcnt_q     <= '0;
         pen_sync_q <= '0;
         touch_q    <= 1'b0;
         pen_en_q   <= 1'b0;
         prech_q    <= 1'b0;
         sense_q    <= 1'b0;
      end else begin
         pst_q      <= pst_d;
         pcnt_q     <= pcnt_d;
         pen_sync_q <= {pen_sync_q[0], pen_pin_i};
         touch_q    <= touch_d;
         pen_en_q   <= pen_en_d;
         prech_q    <= prech_d;
         sense_q    <= sense_d;
      end
   end

   assign pready_o            = pready_q;
   assign prdata_o            = prdata_q;
   assign pslverr_o           = pslverr_q;
   assign conv_allow_o        = allow_q;
   assign buffer_trigger_o    = trig_q;
   assign chan_status_valid_o = stat_q;
   assign ref_internal_o      = rint_q;
   assign ref_power_on_o      = rpow_q;
   assign ref_level_o         = rlvl_q;
   assign ref_settled_o       = rset_q;
   assign pen_detect_enable_o = pen_en_q;
   assign panel_precharge_o   = prech_q;
   assign panel_sense_o       = sense_q;
   assign pen_touch_o         = touch_q;
endmodule : touch_regs

// ==== tb/touch_regs_asserts.sv ====
// port assertions for the touch register bank
`timescale 1ns/1ps
module touch_regs_asserts (
   input wire logic        sys_clk_i,
   input wire logic        nrst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        pslverr_o,
   input wire logic        conv_active_i,
   input wire logic        conv_allow_o,
   input wire logic        buffer_trigger_o,
   input wire logic        chan_status_valid_o,
   input wire logic        ref_internal_o,
   input wire logic        ref_power_on_o,
   input wire logic        ref_settled_o,
   input wire logic        pen_detect_enable_o,
   input wire logic        panel_precharge_o,
   input wire logic        panel_sense_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_unmapped_reads_zero: assert property (pslverr_o && pready_o && !pwrite_i |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_ext_ref_off: assert property (!ref_internal_o [*2] |-> !ref_power_on_o)
      else $error("internal reference on in external mode");
   a_ref_on_demand: assert property (conv_active_i && ref_internal_o ##1 ref_internal_o |-> ref_power_on_o)
      else $error("reference off while converter active");
   a_settle_needs_power: assert property (ref_settled_o |-> ref_power_on_o || $past(ref_power_on_o))
      else $error("settled without power");
   a_pen_phase_excl: assert property (!(panel_precharge_o && panel_sense_o))
      else $error("precharge and sense together");
   a_pen_off_idle: assert property (!pen_detect_enable_o [*3] |-> !panel_precharge_o && !panel_sense_o)
      else $error("pen phases while disabled");
   a_sense_after_pre: assert property ($fell(panel_precharge_o) && pen_detect_enable_o |-> panel_sense_o)
      else $error("precharge not followed by sense");
   a_allow_needs_en: assert property (conv_allow_o |-> !chan_status_valid_o)
      else $error("samples accepted with buffer disabled");
   a_trig_needs_en: assert property (buffer_trigger_o |-> !chan_status_valid_o)
      else $error("trigger with buffer disabled");
endmodule : touch_regs_asserts

bind touch_regs touch_regs_asserts i_touch_regs_asserts (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .conv_active_i(conv_active_i),
   .conv_allow_o(conv_allow_o), .buffer_trigger_o(buffer_trigger_o), .chan_status_valid_o(chan_status_valid_o),
   .ref_internal_o(ref_internal_o), .ref_power_on_o(ref_power_on_o), .ref_settled_o(ref_settled_o),
   .pen_detect_enable_o(pen_detect_enable_o), .panel_precharge_o(panel_precharge_o),
   .panel_sense_o(panel_sense_o));

// ==== tb/conv_model.sv ====
// converter front end: bursts of one result per cycle
`timescale 1ns/1ps
module conv_model (
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       start_i,
   input  wire logic [7:0] burst_i,
   input  wire logic       allow_i,
   output logic            sample_valid_o,
   output logic [11:0]     sample_data_o
);
   logic [7:0]  left_q;
   logic [11:0] val_q;
   // idle data inverted so a stale value never looks valid
   assign sample_data_o = sample_valid_o ? val_q : ~val_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         left_q <= 8'h00;
         sample_valid_o <= 1'b0;
         val_q <= 12'h000;
      end else begin
         left_q <= start_i ? burst_i : (left_q != 8'h00 ? left_q - 8'h01 : left_q);
         sample_valid_o <= !start_i && left_q != 8'h00;
         if (sample_valid_o && allow_i) val_q <= val_q + 12'h001;
      end
   end
endmodule : conv_model

// ==== tb/tb_top.sv ====
// self-checking bench for the touch register bank
`timescale 1ns/1ps
module tb_top;
   import touch_regs_pkg::*;
   // shortened delay tables keep the run brief
   localparam tab4_t R_DLY = '{0, 4, 8, 12};
   localparam tab8_t P_CYC = '{3, 4, 5, 6, 7, 8, 8, 9};
   localparam tab8_t S_CYC = '{4, 5, 6, 7, 8, 9, 10, 11};
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic [11:0] sdata;
   logic [7:0]  burst = 8'h00;
   logic        conv_act = 1'b0, pen_pin = 1'b0, start = 1'b0, seen_pre = 1'b0, seen_sns = 1'b0;
   logic        pready, pslverr, err, valid, allow, trig, chan, r_int, r_on, r_lvl, r_set, pen_en, pre, sns, touch;
   int          error_cnt = 0, n_compared = 0;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (pre) seen_pre <= 1'b1;
      if (sns) seen_sns <= 1'b1;
   end
   touch_regs #(.REF_DLY_CYC(R_DLY), .PRE_CYC(P_CYC), .SENSE_CYC(S_CYC)) i_touch_regs (
      .sys_clk_i(sys_clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .sample_valid_i(valid), .sample_data_i(sdata), .conv_active_i(conv_act), .pen_pin_i(pen_pin),
      .conv_allow_o(allow), .buffer_trigger_o(trig), .chan_status_valid_o(chan), .ref_internal_o(r_int),
      .ref_power_on_o(r_on), .ref_level_o(r_lvl), .ref_settled_o(r_set), .pen_detect_enable_o(pen_en),
      .panel_precharge_o(pre), .panel_sense_o(sns), .pen_touch_o(touch));
   conv_model i_conv_model (.sys_clk_i(sys_clk), .nrst_i(nrst), .start_i(start), .burst_i(burst),
      .allow_i(allow), .sample_valid_o(valid), .sample_data_o(sdata));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk_reg
   task automatic chk_pin(input string n, input logic e, input logic s);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", n, e, s);
      end
   endtask : chk_pin
   task automatic apb(input logic w, input logic [7:0] idx, input logic [15:0] wd);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {16'h0000, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [15:0] v);
      apb(1'b1, idx, v);
   endtask : wr
   task automatic rdchk(input string n, input logic [7:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 16'h0000);
      chk_reg(n, e, rd);
   endtask : rdchk
   task automatic send(input logic [7:0] n);
      @(posedge sys_clk);
      start <= 1'b1;
      burst <= n;
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (int'(n) + 4) @(posedge sys_clk);
   endtask : send
   task automatic defaults();
      rdchk("buf", IDX_BUF, 32'h0000_0200);
      rdchk("ref", IDX_REF, 32'h0000_0002);
      rdchk("rst", IDX_RST, 32'h0000_ffff);
      rdchk("cfg", IDX_CFG, 32'h0000_0000);
   endtask : defaults
   initial begin
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      defaults();
      chk_pin("chan", 1'b1, chan);
      rdchk("unmapped", 8'h07, 32'h0);
      chk_pin("slverr", 1'b1, err);
      wr(IDX_CFG, 16'hffff);
      rdchk("cfg", IDX_CFG, 32'h0000_007f);
      wr(IDX_REF, 16'hffdf);
      rdchk("ref", IDX_REF, 32'h0000_001f);
      // continuous, level 64: one short, then one past full
      wr(IDX_BUF, 16'hb800);
      send(8'd63);
      chk_pin("trig", 1'b0, trig);
      chk_pin("chan", 1'b0, chan);
      send(8'd2);
      chk_pin("trig", 1'b1, trig);
      chk_pin("allow", 1'b0, allow);
      rdchk("buf", IDX_BUF, 32'h0000_bc00);
      for (int i = 0; i < 64; i++) rdchk("data", IDX_DATA, 32'(i));
      rdchk("buf", IDX_BUF, 32'h0000_ba00);
      rdchk("data", IDX_DATA, 32'h0);
      wr(IDX_BUF, 16'hc800);
      send(8'd20);
      chk_pin("trig", 1'b1, trig);
      chk_pin("allow", 1'b0, allow);
      for (int i = 0; i < 16; i++) rdchk("data", IDX_DATA, 32'(i + 65));
      rdchk("buf", IDX_BUF, 32'h0000_ca00);
      wr(IDX_BUF, 16'h4800);
      rdchk("buf", IDX_BUF, 32'h0000_4a00);
      wr(IDX_REF, 16'h0016);
      repeat (3) @(posedge sys_clk);
      chk_pin("ref_on", 1'b0, r_on);
      conv_act <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk_pin("ref_on", 1'b1, r_on);
      chk_pin("settled", 1'b0, r_set);
      repeat (6) @(posedge sys_clk);
      chk_pin("settled", 1'b1, r_set);
      conv_act <= 1'b0;
      wr(IDX_REF, 16'h001d);
      repeat (3) @(posedge sys_clk);
      chk_pin("ref_on", 1'b1, r_on);
      chk_pin("settled", 1'b1, r_set);
      chk_pin("level", 1'b1, r_lvl);
      chk_pin("internal", 1'b1, r_int);
      conv_act <= 1'b1;
      wr(IDX_REF, 16'h0002);
      repeat (3) @(posedge sys_clk);
      chk_pin("internal", 1'b0, r_int);
      chk_pin("ref_on", 1'b0, r_on);
      wr(IDX_BUF, 16'h8000);
      wr(IDX_RST, RESET_CMD);
      defaults();
      seen_pre = 1'b0;
      seen_sns = 1'b0;
      pen_pin <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk_pin("touch", 1'b1, touch);
      chk_pin("phases", 1'b1, seen_pre & seen_sns);
      wr(IDX_CFG, 16'h0040);
      repeat (4) @(posedge sys_clk);
      chk_pin("pen_en", 1'b0, pen_en);
      chk_pin("phase", 1'b0, pre | sns);
      conclude();
   end
   // watchdog well beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      conclude();
   end
endmodule : tb_top
